// [verilog/ppib_top.sv]
// Port pull-up select, SMBus input-buffer select and port-12 latch read-back.
// Assumes a CPU special-register bus: single-cycle read/write strobes, 16-bit
// address, and a per-bit write mask for bit-manipulation instructions.
//
// Summary of operation
// R1: Clock-mode pins read output latch as zero
// R2: Software avoids latch on analog input pins
// R3: Pull-up bit one connects pin pull-up
// R4: Buffer register selects port6 low pin buffers
// R5: Both buffer bits one give SMBus levels
// R6: Buffer register accepts bit and byte writes
// R7: Reset clears buffer register to zero
// R8: Serial out on port6 bit2 when select zero
// R9: Serial out on port12 bit0 when select one
// R10: Serial in on port6 bit1, select zero
// R11: Unimplemented pull-up bits read zero, ignore writes
`timescale 1ns/1ps
module ppib_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // CPU register bus
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wr_bits,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    output logic bus_hit,
    // Port 12 output latch and clock-mode pins
    input wire logic [7:0] port12_latch,
    input wire logic [7:0] port12_clk_pins,
    // Serial routing state from other registers
    input wire logic serial_pin_select,
    input wire logic [7:0] port6_dir,
    input wire logic [7:0] port6_latch,
    input wire logic [7:0] port12_dir,
    input wire logic [7:0] port12_latch_raw,
    input wire logic serial_data_out,
    input wire logic [7:0] port6_pin_in,
    // Pull-up enables per port
    output logic [7:0] pullup_en_p0,
    output logic [7:0] pullup_en_p1,
    output logic [7:0] pullup_en_p3,
    output logic [7:0] pullup_en_p4,
    output logic [7:0] pullup_en_p6,
    output logic [7:0] pullup_en_p7,
    output logic [7:0] pullup_en_p12,
    // Input buffer selects for port6 bits 0 and 1
    output logic [1:0] smbus_buf_sel,
    output logic smbus_levels_active,
    // Serial routing
    output logic port6_bit2_serial_out,
    output logic port6_bit2_serial_en,
    output logic port12_bit0_serial_out,
    output logic port12_bit0_serial_en,
    output logic serial_data_in
);
    localparam int unsigned N = ppib_pkg::NUM_REGS;

    // Address-ordered tables; the buffer select is always the last entry
    localparam logic [15:0] ADDRS [N] = '{
        ppib_pkg::ADDR_PU_P0,
        ppib_pkg::ADDR_PU_P1,
        ppib_pkg::ADDR_PU_P3,
        ppib_pkg::ADDR_PU_P4,
        ppib_pkg::ADDR_PU_P6,
        ppib_pkg::ADDR_PU_P7,
        ppib_pkg::ADDR_PU_P12,
        ppib_pkg::ADDR_SMB_BUF
    };
    localparam logic [7:0] MASKS [N] = '{
        ppib_pkg::MASK_PU_P0,
        ppib_pkg::MASK_PU_P1,
        ppib_pkg::MASK_PU_P3,
        ppib_pkg::MASK_PU_P4,
        ppib_pkg::MASK_PU_P6,
        ppib_pkg::MASK_PU_P7,
        ppib_pkg::MASK_PU_P12,
        ppib_pkg::MASK_SMB_BUF
    };
    localparam logic [7:0] RSTS [N] = '{
        ppib_pkg::RST_PU,
        ppib_pkg::RST_PU,
        ppib_pkg::RST_PU,
        ppib_pkg::RST_PU,
        ppib_pkg::RST_PU,
        ppib_pkg::RST_PU,
        ppib_pkg::RST_PU_P12,
        ppib_pkg::RST_SMB_BUF
    };
    localparam int unsigned IDX_SMB = 7;

    function automatic logic addr_match(input logic [15:0] a, input logic [15:0] ref_a);
        addr_match = (a == ref_a);
    endfunction

    logic [7:0] regs [N];
    logic [N-1:0] sel;
    logic [7:0] p12_read;

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_reg
            assign sel[gi] = addr_match(bus_addr, ADDRS[gi]);
            ppib_cfg_reg #(
                .MASK(MASKS[gi]),
                .RST(RSTS[gi])
            ) u_reg (
                .mclk(mclk),
                .nrst(nrst),
                .wr_en(bus_wr & sel[gi]), // R6
                .wr_bits(bus_wr_bits),
                .wr_data(bus_wdata),
                .value(regs[gi])
            );
        end
    endgenerate

    ppib_latch_read u_p12_rd (
        .latch(port12_latch),
        .clk_pin_mask(port12_clk_pins),
        .rd_value(p12_read)
    );

    // Pull-up copies cover every table entry below the buffer select
    localparam int unsigned NUM_PU = IDX_SMB;

    // Serial output owns a pin only with the right select, direction zero and latch zero
    function automatic logic serial_out_route(
        input logic want_sel,
        input logic pin_sel,
        input logic dir_bit,
        input logic latch_bit
    );
        serial_out_route = (pin_sel == want_sel) && !dir_bit && !latch_bit;
    endfunction

    // Read path
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic hit_q;
    logic hit_d;

    always_comb begin
        // A miss returns the filtered port-12 latch, so one flop serves both kinds of read
        rdata_d = p12_read; // R1
        hit_d = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (bus_rd && sel[i]) begin
                rdata_d = regs[i] & MASKS[i]; // R11
                hit_d = 1'b1;
            end
        end
    end

    // Read answers stand one cycle and are refreshed on every edge
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
            hit_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            hit_q <= hit_d;
        end
    end

    // Pull-up enables, one registered copy per port
    logic [7:0] pu_q [NUM_PU];
    logic [7:0] pu_d [NUM_PU];

    always_comb begin
        // Unimplemented bits are already zero in the registers
        for (int i = 0; i < NUM_PU; i++) begin
            pu_d[i] = regs[i]; // R3
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            // Copies reset to the register values, so port 12 keeps its pull-up through reset
            for (int i = 0; i < NUM_PU; i++) begin
                pu_q[i] <= RSTS[i];
            end
        end else begin
            for (int i = 0; i < NUM_PU; i++) begin
                pu_q[i] <= pu_d[i];
            end
        end
    end

    // Input buffer selects for the two lowest port-6 pins
    logic [1:0] smb_q;
    logic [1:0] smb_d;
    logic smb_lv_q;
    logic smb_lv_d;

    always_comb begin
        smb_d = {regs[IDX_SMB][ppib_pkg::SMB_BIT1], regs[IDX_SMB][ppib_pkg::SMB_BIT0]}; // R4
        // One pin alone on SMBus levels is a mixed setup, so both bits are required
        smb_lv_d = &smb_d; // R5
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            // Normal buffers after any reset
            smb_q <= 2'h0;
            smb_lv_q <= 1'b0;
        end else begin
            smb_q <= smb_d;
            smb_lv_q <= smb_lv_d;
        end
    end

    // Serial output on port-6 bit 2
    // Enable and data register together so the pin never shows a stale mix
    logic p62_o_q;
    logic p62_o_d;
    logic p62_e_q;
    logic p62_e_d;

    always_comb begin
        p62_e_d = serial_out_route(1'b0, serial_pin_select, port6_dir[ppib_pkg::SER_P6_BIT],
            port6_latch[ppib_pkg::SER_P6_BIT]); // R8
        p62_o_d = serial_data_out;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            p62_o_q <= 1'b0;
            p62_e_q <= 1'b0;
        end else begin
            p62_o_q <= p62_o_d;
            p62_e_q <= p62_e_d;
        end
    end

    // Serial output on port-12 bit 0
    // Pin select one moves the serial output here instead of port 6
    logic port12_bit0_o_q;
    logic port12_bit0_o_d;
    logic port12_bit0_e_q;
    logic port12_bit0_e_d;

    always_comb begin
        port12_bit0_e_d = serial_out_route(1'b1, serial_pin_select, port12_dir[ppib_pkg::SER_P12_BIT],
            port12_latch_raw[ppib_pkg::SER_P12_BIT]); // R9
        port12_bit0_o_d = serial_data_out;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            port12_bit0_o_q <= 1'b0;
            port12_bit0_e_q <= 1'b0;
        end else begin
            port12_bit0_o_q <= port12_bit0_o_d;
            port12_bit0_e_q <= port12_bit0_e_d;
        end
    end

    // Serial input; the latch is a don't-care and an unrouted input idles high
    logic si_q;
    logic si_d;

    always_comb begin
        si_d = 1'b1;
        if (!serial_pin_select && port6_dir[ppib_pkg::SER_IN_P6_BIT]) begin
            si_d = port6_pin_in[ppib_pkg::SER_IN_P6_BIT]; // R10
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            si_q <= 1'b1;
        end else begin
            si_q <= si_d;
        end
    end

    // Bus answer
    assign bus_rdata = rdata_q;
    assign bus_hit = hit_q;

    // Pull-up enables
    assign pullup_en_p0 = pu_q[0];
    assign pullup_en_p1 = pu_q[1];
    assign pullup_en_p3 = pu_q[2];
    assign pullup_en_p4 = pu_q[3];
    assign pullup_en_p6 = pu_q[4];
    assign pullup_en_p7 = pu_q[5];
    assign pullup_en_p12 = pu_q[6];

    // Buffer selects
    assign smbus_buf_sel = smb_q;
    assign smbus_levels_active = smb_lv_q;

    // Serial routing
    assign port6_bit2_serial_out = p62_o_q;
    assign port6_bit2_serial_en = p62_e_q;
    assign port12_bit0_serial_out = port12_bit0_o_q;
    assign port12_bit0_serial_en = port12_bit0_e_q;
    assign serial_data_in = si_q;
endmodule

// [pkg/ppib_pkg.sv]
// Package for the port pull-up and input-buffer configuration block.
// Holds register addresses, implemented-bit masks and reset values.
package ppib_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 8;
    localparam logic [15:0] ADDR_PU_P0 = 16'hff30;
    localparam logic [15:0] ADDR_PU_P1 = 16'hff31;
    localparam logic [15:0] ADDR_PU_P3 = 16'hff33;
    localparam logic [15:0] ADDR_PU_P4 = 16'hff34;
    localparam logic [15:0] ADDR_PU_P6 = 16'hff36;
    localparam logic [15:0] ADDR_PU_P7 = 16'hff37;
    localparam logic [15:0] ADDR_PU_P12 = 16'hff3c;
    localparam logic [15:0] ADDR_SMB_BUF = 16'hff3e;
    // Implemented bits per register
    localparam logic [7:0] MASK_PU_P0 = 8'h07;
    localparam logic [7:0] MASK_PU_P1 = 8'hff;
    localparam logic [7:0] MASK_PU_P3 = 8'h0f;
    localparam logic [7:0] MASK_PU_P4 = 8'h07;
    localparam logic [7:0] MASK_PU_P6 = 8'h0f;
    localparam logic [7:0] MASK_PU_P7 = 8'h3f;
    localparam logic [7:0] MASK_PU_P12 = 8'h21;
    localparam logic [7:0] MASK_SMB_BUF = 8'h03;
    localparam logic [7:0] RST_PU = 8'h00;
    localparam logic [7:0] RST_PU_P12 = 8'h20;
    localparam logic [7:0] RST_SMB_BUF = 8'h00;
    localparam int unsigned NUM_REGS = 8;
    localparam int unsigned SMB_BIT0 = 0;
    localparam int unsigned SMB_BIT1 = 1;
    localparam int unsigned SER_P6_BIT = 2;
    localparam int unsigned SER_IN_P6_BIT = 1;
    localparam int unsigned SER_P12_BIT = 0;
endpackage

// [verilog/ppib_cfg_reg.sv]
// One 8-bit configuration register with a mask of implemented bits.
// Assumes single-cycle writes with a bit-write mask from the CPU bus.
`timescale 1ns/1ps
module ppib_cfg_reg #(
    parameter logic [7:0] MASK = 8'hff,
    parameter logic [7:0] RST = 8'h00
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Write side
    input wire logic wr_en,
    input wire logic [7:0] wr_bits,
    input wire logic [7:0] wr_data,
    // Stored value
    output logic [7:0] value
);
    logic [7:0] value_q;
    logic [7:0] value_d;

    always_comb begin
        value_d = value_q;
        if (wr_en) begin
            // Only selected and implemented bits change
            value_d = ((value_q & ~(wr_bits & MASK)) | (wr_data & wr_bits & MASK)) & MASK; // R11
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            value_q <= RST; // R7
        end else begin
            value_q <= value_d;
        end
    end

    assign value = value_q;
endmodule

// [verilog/ppib_latch_read.sv]
// Output-latch read-back filter for one port.
// Assumes the clock generator reports which pins serve the main clock.
`timescale 1ns/1ps
module ppib_latch_read (
    // Latch and clock-pin mask
    input wire logic [7:0] latch,
    input wire logic [7:0] clk_pin_mask,
    // Filtered read value
    output logic [7:0] rd_value
);
    // Clock pins read as zero whatever was written
    assign rd_value = latch & ~clk_pin_mask; // R1
endmodule

// [bench/ppib_top_sva.sv]
// Checker for the pull-up and input-buffer block, bound to its top module.
// Assumes reads answer one cycle later and config outputs lag a write by two edges.
`timescale 1ns/1ps
module ppib_top_sva (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Register bus
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_hit,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wr_bits,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    // Port side
    input wire logic [7:0] port12_latch,
    input wire logic [7:0] port12_clk_pins,
    input wire logic [7:0] port6_dir,
    input wire logic [7:0] port6_latch,
    input wire logic [7:0] port12_dir,
    input wire logic [7:0] port12_latch_raw,
    input wire logic [7:0] port6_pin_in,
    input wire logic [7:0] pullup_en_p0,
    input wire logic [7:0] pullup_en_p12,
    input wire logic serial_pin_select,
    input wire logic serial_data_out,
    input wire logic smbus_levels_active,
    input wire logic port6_bit2_serial_out,
    input wire logic port6_bit2_serial_en,
    input wire logic port12_bit0_serial_out,
    input wire logic port12_bit0_serial_en,
    input wire logic serial_data_in,
    input wire logic [1:0] smbus_buf_sel
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    logic mapped;
    logic [15:0] wa;
    logic [7:0] p12_vis;
    logic sdi_exp;
    logic so6_exp;
    logic so12_exp;
    assign p12_vis = port12_latch & ~port12_clk_pins;
    assign sdi_exp = (!serial_pin_select && port6_dir[1]) ? port6_pin_in[1] : 1'b1;
    assign so6_exp = !serial_pin_select && !port6_dir[2] && !port6_latch[2];
    assign so12_exp = serial_pin_select && !port12_dir[0] && !port12_latch_raw[0];
    assign mapped = bus_addr[15:4] == 12'hff3 && bus_addr[3:0] inside {4'h0, 4'h1, 4'h3, 4'h4, 4'h6, 4'h7, 4'hc, 4'he};
    // Byte writes only, so the expected value needs no old contents
    assign wa = (bus_wr && bus_wr_bits == 8'hff) ? bus_addr : 16'h0;
    property p_rst_buf; !$past(nrst) |-> smbus_buf_sel == 2'h0; endproperty
    property p_pu0; wa == 16'hff30 |-> ##2 pullup_en_p0 == ($past(bus_wdata, 2) & 8'h07); endproperty
    property p_pullup_select_port_twelve; wa == 16'hff3c |-> ##2 pullup_en_p12 == ($past(bus_wdata, 2) & 8'h21); endproperty
    property p_smb; wa == 16'hff3e |-> ##2 {6'h0, smbus_buf_sel} == ($past(bus_wdata, 2) & 8'h03); endproperty
    property p_lvl; smbus_levels_active == &smbus_buf_sel; endproperty
    property p_miss; bus_rd && !mapped |-> ##1 !bus_hit && bus_rdata == $past(p12_vis); endproperty
    property p_hit; bus_rd && mapped |-> ##1 bus_hit; endproperty
    property p_sdi; $past(nrst) |-> serial_data_in == $past(sdi_exp); endproperty
    property p_so6; $past(nrst) |-> port6_bit2_serial_en == $past(so6_exp); endproperty
    property p_so12; $past(nrst) |-> port12_bit0_serial_en == $past(so12_exp); endproperty
    property p_sod;
        $past(nrst) |-> port6_bit2_serial_out == $past(serial_data_out)
            && port12_bit0_serial_out == $past(serial_data_out);
    endproperty
    a_rst_buf: assert property (p_rst_buf) else $error("buffer select not cleared by reset");
    a_pu0: assert property (p_pu0) else $error("port 0 pull-up enables wrong");
    a_pullup_select_port_twelve: assert property (p_pullup_select_port_twelve) else $error("port 12 pull-up enables wrong");
    a_smb: assert property (p_smb) else $error("buffer select does not follow write");
    a_lvl: assert property (p_lvl) else $error("SMBus level flag wrong");
    a_miss: assert property (p_miss) else $error("unmapped read data wrong");
    a_hit: assert property (p_hit) else $error("mapped read not flagged");
    a_sdi: assert property (p_sdi) else $error("serial input routing wrong");
    a_so6: assert property (p_so6) else $error("port 6 serial enable wrong");
    a_so12: assert property (p_so12) else $error("port 12 serial enable wrong");
    a_sod: assert property (p_sod) else $error("serial output data not routed");
    c_bit: cover property (bus_wr && bus_wr_bits != 8'hff);
    c_lvl: cover property (smbus_levels_active);
    c_miss: cover property (bus_rd && !mapped);
endmodule

// [bench/ppib_top_tb.sv]
// Self-checking bench for the pull-up and input-buffer block.
// Assumes the package, design and checker are compiled before this file.
`timescale 1ns/1ps
module ppib_top_tb;
    localparam logic [15:0] RA [8] = '{16'hff30, 16'hff31, 16'hff33, 16'hff34, 16'hff36, 16'hff37, 16'hff3c, 16'hff3e};
    localparam logic [7:0] MK [8] = '{8'h07, 8'hff, 8'h0f, 8'h07, 8'h0f, 8'h3f, 8'h21, 8'h03};
    localparam logic [7:0] RS [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00};
    logic mclk, nrst, bus_wr, bus_rd, bus_hit, serial_pin_select, serial_data_out, smbus_levels_active;
    logic port6_bit2_serial_out, port6_bit2_serial_en, port12_bit0_serial_out, port12_bit0_serial_en, serial_data_in;
    logic [15:0] bus_addr, lf;
    logic [7:0] bus_wr_bits, bus_wdata, bus_rdata, port12_latch, port12_clk_pins, port6_dir, port6_latch, port12_dir;
    logic [7:0] port12_latch_raw, port6_pin_in, pullup_en_p0, pullup_en_p1, pullup_en_p3, pullup_en_p4;
    logic [7:0] pullup_en_p6, pullup_en_p7, pullup_en_p12;
    logic [1:0] smbus_buf_sel;
    logic [8:0] expq [$];
    logic [7:0] po [8];
    logic [7:0] mdl [8];
    logic rd_seen = 1'b0;
    int fail_count = 0;
    int compares = 0;
    ppib_top dut (.mclk(mclk), .nrst(nrst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_wr_bits(bus_wr_bits), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_hit(bus_hit),
        .port12_latch(port12_latch), .port12_clk_pins(port12_clk_pins), .serial_pin_select(serial_pin_select),
        .port6_dir(port6_dir), .port6_latch(port6_latch), .port12_dir(port12_dir),
        .port12_latch_raw(port12_latch_raw), .serial_data_out(serial_data_out), .port6_pin_in(port6_pin_in),
        .pullup_en_p0(pullup_en_p0), .pullup_en_p1(pullup_en_p1), .pullup_en_p3(pullup_en_p3),
        .pullup_en_p4(pullup_en_p4), .pullup_en_p6(pullup_en_p6), .pullup_en_p7(pullup_en_p7),
        .pullup_en_p12(pullup_en_p12), .smbus_buf_sel(smbus_buf_sel), .smbus_levels_active(smbus_levels_active),
        .port6_bit2_serial_out(port6_bit2_serial_out), .port6_bit2_serial_en(port6_bit2_serial_en),
        .port12_bit0_serial_out(port12_bit0_serial_out), .port12_bit0_serial_en(port12_bit0_serial_en),
        .serial_data_in(serial_data_in));
    always_comb po = '{pullup_en_p0, pullup_en_p1, pullup_en_p3, pullup_en_p4, pullup_en_p6, pullup_en_p7,
        pullup_en_p12, {6'h0, smbus_buf_sel}};
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (fail_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // One bus cycle per call, so calls run back to back; port inputs change every cycle
    task automatic op(input logic w, input logic r, input int i, input logic [7:0] bits, input logic [7:0] d);
        @(negedge mclk);
        lf = lfsr(lf);
        {port12_latch, port12_clk_pins} = lf;
        {port6_dir, port6_latch, port12_dir, port12_latch_raw, port6_pin_in} = {lf, lf[11:0], lf[14:3]};
        {serial_pin_select, serial_data_out} = lf[9:8] ^ lf[2:1];
        {bus_wr, bus_rd, bus_wr_bits, bus_wdata} = {w, r, bits, d};
        bus_addr = i < 8 ? RA[i] : (i == 8 ? 16'hff32 : 16'hff3f);
        if (w && i < 8) mdl[i] = (mdl[i] & ~bits) | (d & bits & MK[i]);
        if (r) expq.push_back(i < 8 ? {1'b1, mdl[i]} : {1'b0, port12_latch & ~port12_clk_pins});
    endtask
    task automatic rst();
        @(negedge mclk);
        nrst = 1'b0;
        // Strobes drop with reset so nothing is taken at the first edge after release
        {bus_wr, bus_rd} = 2'b00;
        repeat (10) @(negedge mclk);
        mdl = RS;
        nrst = 1'b1;
    endtask
    task automatic chkpo();
        op(0, 0, 0, 8'h0, 8'h0);
        op(0, 0, 0, 8'h0, 8'h0);
        for (int i = 0; i < 8; i++) chk({1'b0, po[i]}, {1'b0, mdl[i]});
        chk({8'h0, smbus_levels_active}, {8'h0, &mdl[7][1:0]});
    endtask
    always @(posedge mclk) rd_seen <= bus_rd;
    always @(negedge mclk) begin
        if (rd_seen) begin
            if (expq.size() == 0) chk(9'h1ff, 9'h0);
            else chk({bus_hit, bus_rdata}, expq.pop_front());
        end
    end
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        repeat (50000) @(posedge mclk);
        fail_count++;
        final_report();
    end
    initial begin
        nrst = 1'b0;
        lf = 16'hcf85;
        {bus_addr, bus_wr, bus_rd, bus_wr_bits, bus_wdata, port12_latch, port12_clk_pins, serial_pin_select} = '0;
        {port6_dir, port6_latch, port12_dir, port12_latch_raw, serial_data_out, port6_pin_in} = '0;
        rst();
        chkpo();
        for (int i = 0; i < 10; i++) op(0, 1, i, 8'h0, 8'h0);
        for (int k = 0; k < 40; k++) begin
            for (int i = 0; i < 10; i++) op(1, 0, i, k[0] ? 8'(lfsr(lf)) : 8'hff, lf[7:0]);
            for (int i = 0; i < 10; i++) op(0, 1, i, 8'h0, 8'h0);
            chkpo();
        end
        op(1, 0, 7, 8'hff, 8'hff);
        rst();
        op(0, 1, 7, 8'h0, 8'h0);
        chkpo();
        chk({1'b0, 8'(expq.size())}, 9'h0);
        final_report();
    end
endmodule
bind ppib_top ppib_top_sva u_sva (.mclk(mclk), .nrst(nrst), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_hit(bus_hit), .bus_addr(bus_addr), .bus_wr_bits(bus_wr_bits), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .port12_latch(port12_latch), .port12_clk_pins(port12_clk_pins),
    .port6_dir(port6_dir), .port6_latch(port6_latch), .port12_dir(port12_dir),
    .port12_latch_raw(port12_latch_raw), .port6_pin_in(port6_pin_in), .pullup_en_p0(pullup_en_p0),
    .pullup_en_p12(pullup_en_p12), .serial_pin_select(serial_pin_select), .serial_data_out(serial_data_out),
    .smbus_levels_active(smbus_levels_active), .port6_bit2_serial_out(port6_bit2_serial_out),
    .port6_bit2_serial_en(port6_bit2_serial_en), .port12_bit0_serial_out(port12_bit0_serial_out),
    .port12_bit0_serial_en(port12_bit0_serial_en), .serial_data_in(serial_data_in),
    .smbus_buf_sel(smbus_buf_sel));
